// ---- hw/brot_pkg.sv ----
// What this block does
// [RULE_01] Left via carry: carry in, bit7 out, memory
// [RULE_02] Left via carry result to accumulator only
// [RULE_03] Plain right: bit0 to bit7, memory, no flags
// [RULE_04] Plain right to accumulator, memory kept, no flags
// [RULE_05] Right via carry: carry to bit7, memory
// [RULE_06] Right via carry to accumulator, memory kept
// [RULE_07] Left rotations change only the carry flag
// [RULE_08] Eight-bit operands, one cycle per operation
`default_nettype none
package brot_pkg;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] MEM_RST = 8'h00;
  localparam logic CARRY_RST = 1'b0;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  // Flag vector layout.
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_AC = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_OV = 3;

  // ----------------------------------------
  // Operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    BROT_NOP,
    ROTATE_LEFT_VIA_CARRY,
    ROTATE_LEFT_VIA_CARRY_TO_ACCUM,
    ROTATE_RIGHT_PLAIN,
    ROTATE_RIGHT_PLAIN_TO_ACCUM,
    ROTATE_RIGHT_VIA_CARRY,
    ROTATE_RIGHT_VIA_CARRY_TO_ACCUM
  } brot_op_t;

endpackage
`default_nettype wire

// ---- hw/brot_core_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface brot_core_if;
  logic [7:0] src;
  logic cin;
  brot_pkg::brot_op_t op;
  logic [7:0] res;
  logic cout;
  logic to_acc;
  logic to_mem;
  logic use_c;
  modport top (output src, output cin, output op, input res, input cout, input to_acc,
    input to_mem, input use_c);
  modport alu (input src, input cin, input op, output res, output cout, output to_acc,
    output to_mem, output use_c);
endinterface // brot_core_if
`default_nettype wire

// ---- hw/brot_alu.sv ----
`timescale 1ns/1ps
`default_nettype none
module brot_alu (
  brot_core_if.alu c
);

  // ----------------------------------------
  // Combinational rotate
  // ----------------------------------------
  always_comb begin
    c.res = c.src;
    c.cout = c.cin;
    c.to_acc = 1'b0;
    c.to_mem = 1'b0;
    c.use_c = 1'b0;
    case (c.op)
      brot_pkg::ROTATE_LEFT_VIA_CARRY: begin
        c.res = {c.src[6:0], c.cin}; // RULE_01
        c.cout = c.src[7]; // RULE_01
        c.to_mem = 1'b1;
        c.use_c = 1'b1;
      end
      brot_pkg::ROTATE_LEFT_VIA_CARRY_TO_ACCUM: begin
        c.res = {c.src[6:0], c.cin}; // RULE_02
        c.cout = c.src[7]; // RULE_02
        c.to_acc = 1'b1;
        c.use_c = 1'b1;
      end
      brot_pkg::ROTATE_RIGHT_PLAIN: begin
        c.res = {c.src[0], c.src[7:1]}; // RULE_03
        c.to_mem = 1'b1;
      end
      brot_pkg::ROTATE_RIGHT_PLAIN_TO_ACCUM: begin
        c.res = {c.src[0], c.src[7:1]}; // RULE_04
        c.to_acc = 1'b1;
      end
      brot_pkg::ROTATE_RIGHT_VIA_CARRY: begin
        c.res = {c.cin, c.src[7:1]}; // RULE_05
        c.cout = c.src[0]; // RULE_05
        c.to_mem = 1'b1;
        c.use_c = 1'b1;
      end
      brot_pkg::ROTATE_RIGHT_VIA_CARRY_TO_ACCUM: begin
        c.res = {c.cin, c.src[7:1]}; // RULE_06
        c.cout = c.src[0]; // RULE_06
        c.to_acc = 1'b1;
        c.use_c = 1'b1;
      end
      default: begin
        c.res = c.src;
      end
    endcase
  end

endmodule // brot_alu
`default_nettype wire

// ---- hw/brot_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module brot_unit (
  input wire logic mclk,
  input wire logic rst,
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [7:0] mem_rdata,
  input wire logic [3:0] flags_in,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic acc_we,
  output logic [7:0] acc_wdata,
  output logic flags_we,
  output logic [3:0] flags_out,
  output logic done
);

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  brot_core_if cif ();

  brot_alu u_alu (
    .c(cif)
  );

  logic mem_we_q;
  logic mem_we_d;
  logic acc_we_q;
  logic acc_we_d;
  logic flags_we_q;
  logic flags_we_d;
  logic done_q;
  logic done_d;
  logic [7:0] mem_wdata_q;
  logic [7:0] mem_wdata_d;
  logic [7:0] acc_wdata_q;
  logic [7:0] acc_wdata_d;
  logic [3:0] flags_q;
  logic [3:0] flags_d;

  assign cif.src = mem_rdata;
  assign cif.cin = flags_in[brot_pkg::FLAG_C];
  // An idle cycle feeds the no-operation code, so a stale code can never write.
  assign cif.op = op_valid ? brot_pkg::brot_op_t'(op_code) : brot_pkg::BROT_NOP;

  // One registered stage: every operation answers exactly one cycle later.
  always_comb begin
    mem_we_d = cif.to_mem; // RULE_08
    acc_we_d = cif.to_acc; // RULE_08
    mem_wdata_d = cif.to_mem ? cif.res : mem_wdata_q;
    acc_wdata_d = cif.to_acc ? cif.res : acc_wdata_q;
    flags_we_d = cif.use_c;
    // Only carry moves; the other flags pass through so the core keeps them.
    flags_d = flags_in;
    flags_d[brot_pkg::FLAG_C] = cif.cout; // RULE_07
    if (!cif.use_c) begin
      flags_d = flags_q;
    end
    done_d = op_valid;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_we_q <= 1'b0;
      acc_we_q <= 1'b0;
      flags_we_q <= 1'b0;
      done_q <= 1'b0;
      mem_wdata_q <= brot_pkg::MEM_RST;
      acc_wdata_q <= brot_pkg::ACC_RST;
      flags_q <= brot_pkg::FLAGS_RST;
    end else begin
      mem_we_q <= mem_we_d;
      acc_we_q <= acc_we_d;
      flags_we_q <= flags_we_d;
      done_q <= done_d;
      mem_wdata_q <= mem_wdata_d;
      acc_wdata_q <= acc_wdata_d;
      flags_q <= flags_d;
    end
  end

  assign mem_we = mem_we_q;
  assign mem_wdata = mem_wdata_q;
  assign acc_we = acc_we_q;
  assign acc_wdata = acc_wdata_q;
  assign flags_we = flags_we_q;
  assign flags_out = flags_q;
  assign done = done_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // The checks decode the raw pins, so the one spare code 3'h7 is watched along with the no-operation code.
  function logic brot_is_left_carry(input logic [2:0] code);
    return code == 3'h1 || code == 3'h2;
  endfunction

  function logic brot_is_right_carry(input logic [2:0] code);
    return code == 3'h5 || code == 3'h6;
  endfunction

  function logic brot_is_plain(input logic [2:0] code);
    return code == 3'h3 || code == 3'h4;
  endfunction

  function logic brot_is_nop(input logic [2:0] code);
    return code == 3'h0 || code == 3'h7;
  endfunction

  sequence s_left_carry_mem_issue;
    op_valid && op_code == 3'h1;
  endsequence

  sequence s_left_carry_acc_issue;
    op_valid && op_code == 3'h2;
  endsequence

  sequence s_right_plain_mem_issue;
    op_valid && op_code == 3'h3;
  endsequence

  sequence s_right_plain_acc_issue;
    op_valid && op_code == 3'h4;
  endsequence

  sequence s_right_carry_mem_issue;
    op_valid && op_code == 3'h5;
  endsequence

  sequence s_right_carry_acc_issue;
    op_valid && op_code == 3'h6;
  endsequence

  sequence s_issue_then_idle;
    op_valid ##1 !op_valid;
  endsequence

  sequence s_answer_then_quiet;
    done ##1 !done && !mem_we && !acc_we && !flags_we;
  endsequence

  AST_LEFT_CARRY_MEM: assert property (@(posedge mclk) disable iff (rst) // RULE_01
    s_left_carry_mem_issue |=> mem_we && !acc_we && flags_we
      && mem_wdata == {$past(mem_rdata[6:0]), $past(flags_in[0])}
      && flags_out[0] == $past(mem_rdata[7]))
    else $error("left via carry to memory wrong");

  AST_LEFT_CARRY_ACC: assert property (@(posedge mclk) disable iff (rst) // RULE_02
    s_left_carry_acc_issue |=> acc_we && !mem_we && flags_we
      && acc_wdata == {$past(mem_rdata[6:0]), $past(flags_in[0])}
      && flags_out[0] == $past(mem_rdata[7]))
    else $error("left via carry to accumulator wrong");

  AST_RIGHT_PLAIN_MEM: assert property (@(posedge mclk) disable iff (rst) // RULE_03
    s_right_plain_mem_issue |=> mem_we && !acc_we && !flags_we
      && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
    else $error("plain right to memory wrong");

  AST_RIGHT_PLAIN_ACC: assert property (@(posedge mclk) disable iff (rst) // RULE_04
    s_right_plain_acc_issue |=> acc_we && !mem_we && !flags_we
      && acc_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
    else $error("plain right to accumulator wrong");

  AST_RIGHT_CARRY_MEM: assert property (@(posedge mclk) disable iff (rst) // RULE_05
    s_right_carry_mem_issue |=> mem_we && !acc_we && flags_we
      && mem_wdata == {$past(flags_in[0]), $past(mem_rdata[7:1])}
      && flags_out[0] == $past(mem_rdata[0]))
    else $error("right via carry to memory wrong");

  AST_RIGHT_CARRY_ACC: assert property (@(posedge mclk) disable iff (rst) // RULE_06
    s_right_carry_acc_issue |=> acc_we && !mem_we && flags_we
      && acc_wdata == {$past(flags_in[0]), $past(mem_rdata[7:1])}
      && flags_out[0] == $past(mem_rdata[0]))
    else $error("right via carry to accumulator wrong");

  AST_LEFT_FLAGS: assert property (@(posedge mclk) disable iff (rst) // RULE_07
    op_valid && brot_is_left_carry(op_code) |=>
      flags_out[3:1] == $past(flags_in[3:1]))
    else $error("left rotation changed a flag other than carry");

  AST_RIGHT_FLAGS: assert property (@(posedge mclk) disable iff (rst) // RULE_05
    op_valid && brot_is_right_carry(op_code) |=>
      flags_out[3:1] == $past(flags_in[3:1]))
    else $error("right rotation changed a flag other than carry");

  AST_PLAIN_FLAGS: assert property (@(posedge mclk) disable iff (rst) // RULE_03
    op_valid && brot_is_plain(op_code) |=>
      !flags_we && $stable(flags_out))
    else $error("plain rotation touched the flags");

  AST_NOP_QUIET: assert property (@(posedge mclk) disable iff (rst) // RULE_08
    op_valid && brot_is_nop(op_code) |=>
      done && !mem_we && !acc_we && !flags_we)
    else $error("spare code wrote a result");

  // Data outputs hold between writes, so a late strobe cannot pick up a stale byte.
  AST_MEM_WDATA_HOLDS: assert property (@(posedge mclk) disable iff (rst) // RULE_08
    !mem_we |-> $stable(mem_wdata))
    else $error("memory data moved without a write");

  AST_ACC_WDATA_HOLDS: assert property (@(posedge mclk) disable iff (rst) // RULE_08
    !acc_we |-> $stable(acc_wdata))
    else $error("accumulator data moved without a write");

  AST_FLAGS_HOLD: assert property (@(posedge mclk) disable iff (rst) // RULE_07
    !flags_we |-> $stable(flags_out))
    else $error("flags moved without a write");

  AST_ONE_TARGET: assert property (@(posedge mclk) disable iff (rst) // RULE_02
    !(mem_we && acc_we))
    else $error("result written to memory and accumulator at once");

  AST_DONE_ONLY_AFTER_ISSUE: assert property (@(posedge mclk) disable iff (rst) // RULE_08
    !op_valid |=> !done)
    else $error("done without an issued operation");

  AST_ONE_CYCLE: assert property (@(posedge mclk) disable iff (rst) // RULE_08
    s_issue_then_idle |-> s_answer_then_quiet)
    else $error("operation not exactly one cycle");

endmodule // brot_unit
`default_nettype wire

// ---- tb/brot_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far side: one data-memory byte and the flag register of the core.
module brot_far_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ld,
  input wire logic [7:0] ld_mem,
  input wire logic [3:0] ld_flags,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic flags_we,
  input wire logic [3:0] flags_out,
  output logic [7:0] mem_q,
  output logic [3:0] flags_q
);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_q <= 8'h00;
      flags_q <= 4'h0;
    end else if (ld) begin
      mem_q <= ld_mem;
      flags_q <= ld_flags;
    end else begin
      if (mem_we) mem_q <= mem_wdata;
      if (flags_we) flags_q <= flags_out;
    end
  end
endmodule // brot_far_model
`default_nettype wire

// ---- tb/byte_rotate_unit_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_rotate_unit_tb;
  logic mclk = 1'b0, rst = 1'b1, op_valid = 1'b0, ld = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic [7:0] ld_mem = 8'h00, mem_q, mem_wdata, acc_wdata;
  logic [3:0] ld_flags = 4'h0, flags_q, flags_out;
  logic mem_we, acc_we, flags_we, done;
  int fail_count = 0, checks = 0;
  always #5 mclk = ~mclk;
  brot_unit uut (.mclk(mclk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .mem_rdata(mem_q), .flags_in(flags_q), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .acc_we(acc_we), .acc_wdata(acc_wdata), .flags_we(flags_we), .flags_out(flags_out),
    .done(done));
  brot_far_model far (.mclk(mclk), .rst(rst), .ld(ld), .ld_mem(ld_mem), .ld_flags(ld_flags),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .flags_we(flags_we), .flags_out(flags_out),
    .mem_q(mem_q), .flags_q(flags_q));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Expected results come from the rotate definitions, not from the unit.
  task automatic run(input logic [2:0] k, input logic [7:0] m, input logic [3:0] f);
    logic [7:0] r;
    logic c;
    logic vm, va, vf;
    c = f[0];
    r = 8'h00;
    if (k == 3'h1 || k == 3'h2) {c, r} = {m, f[0]};
    if (k == 3'h3 || k == 3'h4) r = {m[0], m[7:1]};
    if (k == 3'h5 || k == 3'h6) {r, c} = {f[0], m};
    vm = k inside {3'h1, 3'h3, 3'h5};
    va = k inside {3'h2, 3'h4, 3'h6};
    vf = k inside {3'h1, 3'h2, 3'h5, 3'h6};
    ld = 1'b1;
    ld_mem = m;
    ld_flags = f;
    @(negedge mclk);
    ld = 1'b0;
    op_valid = 1'b1;
    op_code = k;
    @(negedge mclk);
    op_valid = 1'b0;
    chk("done", done, 8'h01);
    chk("mem_we", mem_we, vm);
    chk("acc_we", acc_we, va);
    chk("flags_we", flags_we, vf);
    if (vm) chk("mem_wdata", mem_wdata, r);
    if (va) chk("acc_wdata", acc_wdata, r);
    if (vf) chk("flags_out", flags_out, {f[3:1], c});
    @(negedge mclk);
    chk("done_end", done, 8'h00);
    chk("mem", mem_q, vm ? r : m);
    chk("flags", flags_q, vf ? {f[3:1], c} : f);
  endtask
  task automatic t_mem;
    run(3'h1, 8'h81, 4'he);
    run(3'h1, 8'h7e, 4'h1);
    run(3'h3, 8'h81, 4'hf);
    run(3'h5, 8'h01, 4'h0);
    run(3'h5, 8'h80, 4'hb);
    $display("t_mem ended");
  endtask
  task automatic t_acc;
    run(3'h2, 8'h80, 4'h6);
    run(3'h4, 8'h01, 4'h9);
    run(3'h6, 8'h02, 4'hf);
    run(3'h6, 8'hff, 4'h0);
    $display("t_acc ended");
  endtask
  task automatic t_nop;
    run(3'h0, 8'h5a, 4'h3);
    run(3'h7, 8'ha5, 4'hc);
    $display("t_nop ended");
  endtask
  // Two operations on consecutive edges; both read the same operands.
  task automatic t_b2b;
    run(3'h0, 8'h96, 4'h1);
    op_valid = 1'b1;
    op_code = 3'h4;
    @(negedge mclk);
    op_code = 3'h2;
    chk("b2b_acc1", acc_wdata, 8'h4b);
    @(negedge mclk);
    op_valid = 1'b0;
    chk("b2b_done", done, 8'h01);
    chk("b2b_acc2", acc_wdata, 8'h2d);
    $display("t_b2b ended");
  endtask
  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    t_mem;
    t_acc;
    t_nop;
    t_b2b;
    test_done;
  end
  initial begin
    #100us;
    fail_count++;
    test_done;
  end
endmodule // byte_rotate_unit_tb
`default_nettype wire
